// ---- hw/cfr_defs.svh ----
// cfr_defs.svh: offsets, field positions, frame and timing constants of the reader controller.
// assumes a 25 MHz system clock and a card answering over a manchester link.
// How it works
// RL1: one command frame goes out, then one response frame is awaited.
// RL2: bytes go msb first, no start, parity, stop bits or gaps.
// RL3: manchester coding both ways at 212 or 424 kbps.
// RL4: each frame opens with six zero bytes and sync pattern b24d.
// RL5: length byte is data byte count plus one, marks where crc starts.
// RL6: command message goes out, response message comes back in data field.
// RL7: two-byte crc x16+x12+x5+1, preset zero, generated and checked.
// RL8: card compares the request system code with its stored one.
// RL9: wildcard system code ffff is answered by any card.
// RL10: system code aaff matches any card whose stored upper byte is aa.
// RL11: any other system code needs an exact match, else no answer.
// RL12: request answer carries the eight-byte card identifier.
// RL13: descriptor bytes 0,1,7 are ff, bytes 2-4 zero, 5-6 stored.
// RL14: descriptor byte 5 times reads, byte 6 times writes.
// RL15: timing byte holds E in bits 7:6, B in 5:3, A in 2:0.
// RL16: reader waits at most T*((B+1)*n+(A+1))*4^E for the reply.
// RL17: card always answers a request in the first time slot.
// RL18: stored system code defaults aa, ff.
// RL19: stored timing bytes default ff and feed descriptor bytes 5, 6.
// RL20: a frame with bad crc or inconsistent length gets no answer.
`ifndef CFR_DEFS_SVH
`define CFR_DEFS_SVH
`define CFR_A_CTRL 12'h000
`define CFR_A_STAT 12'h004
`define CFR_A_TXLEN 12'h008
`define CFR_A_TIME 12'h00C
`define CFR_A_TXBUF 12'h100
`define CFR_A_RXBUF 12'h200
`define CFR_A_BUFMASK 12'hF80
`define CFR_CTRL_START 0
`define CFR_CTRL_RATE 1
`define CFR_PRE_BYTES 6'h06
`define CFR_SYNC 16'hB24D
`define CFR_CRC_POLY 16'h1021
`define CFR_CRC_INIT 16'h0000
`define CFR_RX_MAXLEN 8'h1E
`define CFR_CLK_KHZ 25000
`define CFR_CARRIER_KHZ 13560
`define CFR_T_CARRIERS 4096
`define CFR_RATE_LO_KBPS 212
`define CFR_RATE_HI_KBPS 424
`define CFR_HALF_LO (`CFR_CLK_KHZ / (2 * `CFR_RATE_LO_KBPS))
`define CFR_HALF_HI (`CFR_CLK_KHZ / (2 * `CFR_RATE_HI_KBPS))
`define CFR_T_CYCLES (`CFR_T_CARRIERS * `CFR_CLK_KHZ / `CFR_CARRIER_KHZ)
`endif

// ---- hw/cfr_pkg.sv ----
// cfr_pkg: types of the reader controller.
// assumes cfr_defs.svh for all numeric constants.
package cfr_pkg;
   typedef enum logic [4:0] {
      CFR_IDLE = 5'b00001,
      CFR_TX = 5'b00010,
      CFR_WAIT = 5'b00100,
      CFR_RX = 5'b01000,
      CFR_END = 5'b10000
   } cfr_state_t;
   typedef struct packed {
      logic [7:0] rx_len;
      logic len_err;
      logic timeout;
      logic crc_ok;
      logic done;
   } cfr_status_t;
endpackage

// ---- hw/cfr_reader.sv ----
// cfr_reader: reader-side framer, sends one command frame and receives the card's answer.
// assumes an axi4-lite master on the register side and a manchester rf front end on rf_tx/rf_rx.
`timescale 1ns/1ps
`include "cfr_defs.svh"
module cfr_reader #(
   parameter int unsigned T_CYCLES = `CFR_T_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic rf_tx,
   input wire logic rf_rx,
   output cfr_pkg::cfr_status_t status
);
   import cfr_pkg::*;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         x = (x[15] ^ d[i]) ? ({x[14:0], 1'b0} ^ `CFR_CRC_POLY) : {x[14:0], 1'b0};
      end
      return x;
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      return a == `CFR_A_CTRL || a == `CFR_A_STAT || a == `CFR_A_TXLEN || a == `CFR_A_TIME ||
         (a & `CFR_A_BUFMASK) == `CFR_A_TXBUF || (a & `CFR_A_BUFMASK) == `CFR_A_RXBUF;
   endfunction

   // axi slave
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, rd_word;
   logic wr_go;
   // software registers
   logic start_r, start_nxt, rate_r, rate_nxt;
   logic [4:0] txlen_r, txlen_nxt;
   logic [7:0] tparam_r, tparam_nxt;
   logic [3:0] tblk_r, tblk_nxt;
   logic [7:0] txbuf [32];
   logic [7:0] rxbuf [32];
   // engine
   cfr_state_t st_r, st_nxt;
   logic [5:0] tb_r, tb_nxt, nidx;
   logic [2:0] bit_r, bit_nxt, rbit_r, rbit_nxt;
   logic half_r, half_nxt, tx_r, tx_nxt;
   logic [6:0] hc_r, hc_nxt, lk_r, lk_nxt, half_c, lk_c;
   logic [7:0] cur_r, cur_nxt, nb, rbyte;
   logic [15:0] crc_r, crc_nxt, sh_r, sh_nxt, crc_n;
   logic [31:0] wc_r, wc_nxt, lim_r, lim_nxt;
   logic [5:0] rcnt_r, rcnt_nxt;
   cfr_status_t stat_r, stat_nxt;
   logic rx_we, rbit_v;
   logic rx1_r, rx2_r, rxp_r;

   assign wr_go = aw_have_r && w_have_r && !bvalid_r;

   always_comb begin
      aw_have_nxt = aw_have_r;
      awaddr_nxt = awaddr_r;
      w_have_nxt = w_have_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = addr_ok(awaddr_r) ? 2'h0 : 2'h2;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt = !w_have_nxt && !bvalid_nxt;
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rresp_nxt = addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      // ready follows the read slot, so it rises one edge after reset
      arready_nxt = !rvalid_nxt;
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      if (s_axi_araddr == `CFR_A_CTRL) begin
         rd_word[`CFR_CTRL_RATE] = rate_r;
      end else if (s_axi_araddr == `CFR_A_STAT) begin
         rd_word = {19'h0_0000, stat_r, st_r != CFR_IDLE};
      end else if (s_axi_araddr == `CFR_A_TXLEN) begin
         rd_word = {27'h000_0000, txlen_r};
      end else if (s_axi_araddr == `CFR_A_TIME) begin
         rd_word = {20'h0_0000, tblk_r, tparam_r};
      end else if ((s_axi_araddr & `CFR_A_BUFMASK) == `CFR_A_TXBUF) begin
         rd_word = {24'h00_0000, txbuf[s_axi_araddr[6:2]]};
      end else if ((s_axi_araddr & `CFR_A_BUFMASK) == `CFR_A_RXBUF) begin
         rd_word = {24'h00_0000, rxbuf[s_axi_araddr[6:2]]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_have_r <= 1'b0;
         awaddr_r <= 12'h000;
         w_have_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
      end else begin
         aw_have_r <= aw_have_nxt;
         awaddr_r <= awaddr_nxt;
         w_have_r <= w_have_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // software registers; only byte lane 0 and 1 carry fields
   always_comb begin
      start_nxt = 1'b0;
      rate_nxt = rate_r;
      txlen_nxt = txlen_r;
      tparam_nxt = tparam_r;
      tblk_nxt = tblk_r;
      if (wr_go && wstrb_r[0] && awaddr_r == `CFR_A_CTRL) begin
         start_nxt = wdata_r[`CFR_CTRL_START];
         rate_nxt = wdata_r[`CFR_CTRL_RATE];
      end
      if (wr_go && wstrb_r[0] && awaddr_r == `CFR_A_TXLEN) begin
         txlen_nxt = wdata_r[4:0];
      end
      if (wr_go && awaddr_r == `CFR_A_TIME) begin
         if (wstrb_r[0]) tparam_nxt = wdata_r[7:0];
         if (wstrb_r[1]) tblk_nxt = wdata_r[11:8];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_r <= 1'b0;
         rate_r <= 1'b0;
         txlen_r <= 5'h00;
         tparam_r <= 8'hFF;
         tblk_r <= 4'h1;
      end else begin
         start_r <= start_nxt;
         rate_r <= rate_nxt;
         txlen_r <= txlen_nxt;
         tparam_r <= tparam_nxt;
         tblk_r <= tblk_nxt;
      end
   end

   // buffers carry no reset; software fills txbuf before starting
   always_ff @(posedge clk) begin
      if (wr_go && wstrb_r[0] && (awaddr_r & `CFR_A_BUFMASK) == `CFR_A_TXBUF) begin
         txbuf[awaddr_r[6:2]] <= wdata_r[7:0];
      end
      if (rx_we) begin
         rxbuf[rcnt_r[4:0]] <= rbyte;
      end
   end

   // rf_rx comes from the analog front end: two flops, third flop for edge detect and as the sampled bit value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx1_r <= 1'b0;
         rx2_r <= 1'b0;
         rxp_r <= 1'b0;
      end else begin
         rx1_r <= rf_rx;
         rx2_r <= rx1_r;
         rxp_r <= rx2_r;
      end
   end

   assign half_c = rate_r ? 7'(`CFR_HALF_HI - 1) : 7'(`CFR_HALF_LO - 1);
   assign lk_c = rate_r ? 7'(3 * `CFR_HALF_HI / 2) : 7'(3 * `CFR_HALF_LO / 2);

   // next frame byte: preamble, sync, length, data, crc [RL4] [RL5] [RL6] [RL7]
   always_comb begin
      nidx = 6'(tb_r + 6'h01);
      if (nidx < `CFR_PRE_BYTES) nb = 8'h00;
      else if (nidx == `CFR_PRE_BYTES) nb = 8'(`CFR_SYNC >> 8);
      else if (nidx == 6'(`CFR_PRE_BYTES + 6'h01)) nb = 8'(`CFR_SYNC);
      else if (nidx == 6'(`CFR_PRE_BYTES + 6'h02)) nb = 8'(txlen_r) + 8'h01;
      else if (nidx <= 6'(txlen_r + 6'h08)) nb = txbuf[5'(nidx - 6'h09)];
      else if (nidx == 6'(txlen_r + 6'h09)) nb = crc_r[15:8];
      else nb = crc_r[7:0];
   end

   assign rbit_v = rxp_r;
   assign rbyte = {sh_r[6:0], rbit_v};
   assign crc_n = crc_byte(crc_r, rbyte);

   always_comb begin
      st_nxt = st_r;
      tb_nxt = tb_r;
      bit_nxt = bit_r;
      half_nxt = half_r;
      hc_nxt = hc_r;
      cur_nxt = cur_r;
      crc_nxt = crc_r;
      tx_nxt = tx_r;
      wc_nxt = wc_r;
      lim_nxt = lim_r;
      lk_nxt = lk_r;
      sh_nxt = sh_r;
      rbit_nxt = rbit_r;
      rcnt_nxt = rcnt_r;
      stat_nxt = stat_r;
      rx_we = 1'b0;
      unique case (st_r)
         CFR_IDLE: begin
            if (start_r) begin
               st_nxt = CFR_TX; // [RL1]
               stat_nxt = '0;
               tb_nxt = 6'h00;
               bit_nxt = 3'h7;
               half_nxt = 1'b0;
               hc_nxt = half_c;
               cur_nxt = 8'h00;
               crc_nxt = `CFR_CRC_INIT; // [RL7]
               tx_nxt = 1'b0;
               // longest wait for the answer [RL16] [RL15] [RL14]
               lim_nxt = 32'((32'(tparam_r[5:3]) + 32'h1) * 32'(tblk_r) + 32'(tparam_r[2:0])
                  + 32'h1) * 32'(T_CYCLES) << (2 * tparam_r[7:6]);
            end
         end
         CFR_TX: begin
            if (hc_r != 7'h00) begin
               hc_nxt = 7'(hc_r - 7'h01);
            end else begin
               hc_nxt = half_c;
               if (!half_r) begin
                  half_nxt = 1'b1;
                  tx_nxt = !cur_r[bit_r]; // mid-bit transition [RL3]
               end else begin
                  half_nxt = 1'b0;
                  if (bit_r != 3'h0) begin
                     bit_nxt = 3'(bit_r - 3'h1); // [RL2]
                     tx_nxt = cur_r[3'(bit_r - 3'h1)];
                  end else if (tb_r == 6'(txlen_r + 6'h0A)) begin
                     st_nxt = CFR_WAIT;
                     tx_nxt = 1'b0;
                     wc_nxt = 32'h0000_0000;
                     sh_nxt = 16'h0000;
                     lk_nxt = 7'h00;
                  end else begin
                     tb_nxt = nidx; // next byte follows with no gap [RL2]
                     cur_nxt = nb;
                     bit_nxt = 3'h7;
                     tx_nxt = nb[7];
                     if (nidx >= 6'h08 && nidx <= 6'(txlen_r + 6'h08)) begin
                        crc_nxt = crc_byte(crc_r, nb);
                     end
                  end
               end
            end
         end
         CFR_WAIT, CFR_RX: begin
            // card answers in the first slot, so one window covers it [RL17]
            if (wc_r >= lim_r) begin
               st_nxt = CFR_END;
               stat_nxt.timeout = 1'b1; // [RL16]
            end else begin
               wc_nxt = 32'(wc_r + 32'h1);
            end
            // a mid-bit edge carries the bit; edges within 3/4 bit are cell boundaries
            if (lk_r != 7'h00) begin
               lk_nxt = 7'(lk_r - 7'h01);
            end else if (rx2_r ^ rxp_r) begin
               lk_nxt = lk_c; // [RL3]
               sh_nxt = {sh_r[14:0], rbit_v};
               if (st_r == CFR_WAIT && {sh_r[14:0], rbit_v} == `CFR_SYNC && wc_r < lim_r) begin
                  st_nxt = CFR_RX; // [RL4]
                  rbit_nxt = 3'h0;
                  rcnt_nxt = 6'h00;
                  crc_nxt = `CFR_CRC_INIT;
               end else if (st_r == CFR_RX && wc_r < lim_r) begin
                  rbit_nxt = 3'(rbit_r + 3'h1);
                  if (rbit_r == 3'h7) begin
                     rx_we = 1'b1;
                     crc_nxt = crc_n;
                     rcnt_nxt = 6'(rcnt_r + 6'h01);
                     if (rcnt_r == 6'h00) begin
                        stat_nxt.rx_len = rbyte;
                        if (rbyte == 8'h00 || rbyte > `CFR_RX_MAXLEN) begin
                           st_nxt = CFR_END;
                           stat_nxt.len_err = 1'b1; // [RL5] [RL20]
                        end
                     end else if ({2'b00, rcnt_r} == 8'(stat_r.rx_len + 8'h01)) begin
                        st_nxt = CFR_END;
                        stat_nxt.crc_ok = (crc_n == 16'h0000); // [RL7] [RL20]
                     end
                  end
               end
            end
         end
         CFR_END: begin
            st_nxt = CFR_IDLE;
            stat_nxt.done = 1'b1;
         end
         default: st_nxt = CFR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= CFR_IDLE;
         tb_r <= 6'h00;
         bit_r <= 3'h7;
         half_r <= 1'b0;
         hc_r <= 7'h00;
         cur_r <= 8'h00;
         crc_r <= 16'h0000;
         tx_r <= 1'b0;
         wc_r <= 32'h0000_0000;
         lim_r <= 32'h0000_0000;
         lk_r <= 7'h00;
         sh_r <= 16'h0000;
         rbit_r <= 3'h0;
         rcnt_r <= 6'h00;
         stat_r <= '0;
      end else begin
         st_r <= st_nxt;
         tb_r <= tb_nxt;
         bit_r <= bit_nxt;
         half_r <= half_nxt;
         hc_r <= hc_nxt;
         cur_r <= cur_nxt;
         crc_r <= crc_nxt;
         tx_r <= tx_nxt;
         wc_r <= wc_nxt;
         lim_r <= lim_nxt;
         lk_r <= lk_nxt;
         sh_r <= sh_nxt;
         rbit_r <= rbit_nxt;
         rcnt_r <= rcnt_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign rf_tx = tx_r;
   assign status = stat_r;

   a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
      st_r != CFR_TX |-> !tx_r) else $error("link driven outside a frame");
   a_start_frame: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
      st_r == CFR_IDLE && start_r |=> st_r == CFR_TX && tb_r == 6'h00 && crc_r == 16'h0000)
      else $error("frame start not clean");
   a_preamble_zero: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      st_r == CFR_TX && tb_r < `CFR_PRE_BYTES |-> cur_r == 8'h00) else $error("preamble not zero");
   a_sync_pair: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      st_r == CFR_TX && tb_r == 6'h07 |-> {$past(cur_r, 1), cur_r} == `CFR_SYNC ||
      $past(tb_r) == 6'h07) else $error("sync pattern wrong");
   a_len_byte: assert property (@(posedge clk) disable iff (!rstn) // [RL5]
      st_r == CFR_TX && tb_r == 6'h08 |-> cur_r == 8'(txlen_r) + 8'h01)
      else $error("length byte wrong");
   a_mid_edge: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
      st_r == CFR_TX && hc_r == 7'h00 && !half_r |=> tx_r != $past(tx_r)) else $error("no mid-bit edge");
   a_msb_first: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
      st_r == CFR_TX && hc_r == 7'h00 && half_r && bit_r != 3'h0
      |=> bit_r == 3'($past(bit_r) - 3'h1))
      else $error("bit order wrong");
   a_wait_bound: assert property (@(posedge clk) disable iff (!rstn) // [RL16]
      st_r == CFR_WAIT || st_r == CFR_RX |-> wc_r <= lim_r) else $error("wait overran limit");
   a_resp_hold: assert property (@(posedge clk) disable iff (!rstn)
      bvalid_r && !s_axi_bready |=> bvalid_r) else $error("write response dropped");
endmodule // cfr_reader

// ---- tb/cfr_card_model.sv ----
// cfr_card_model: behavioural proximity card that answers request frames.
// assumes the reader drives rf_tx manchester coded, low when idle.
`timescale 1ns/1ps
module cfr_card_model #(
   parameter logic [63:0] CARD_ID = 64'h0123_4567_89ab_cdef, // arbitrary value
   parameter logic [7:0] TIME_RD = 8'hff,
   parameter logic [7:0] TIME_WR = 8'hff,
   parameter logic [7:0] REQ_CMD = 8'h00,
   parameter logic [7:0] REQ_RSP = 8'h01,
   parameter int RESP_DLY = 40
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rf_tx,
   output logic rf_rx,
   input wire logic [7:0] half,
   input wire logic [15:0] sys_code,
   input wire logic bad_crc,
   output logic [7:0] got_cnt
);
   logic v;
   logic [15:0] sh;
   logic [7:0] fb [0:31];
   function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction
   // resync on every mid-bit edge so a one-cycle rate mismatch cannot drift
   task automatic get_bit();
      while (rf_tx == v) @(posedge clk);
      repeat (half + half / 2) @(posedge clk);
      v = rf_tx;
      sh = {sh[14:0], v};
   endtask
   task automatic get_byte(output logic [7:0] b);
      repeat (8) get_bit();
      b = sh[7:0];
   endtask
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         rf_rx <= b[i];
         repeat (half) @(posedge clk);
         rf_rx <= ~b[i];
         repeat (half) @(posedge clk);
      end
   endtask
   task automatic put_frame(input int n);
      logic [15:0] c;
      c = 16'h0000;
      repeat (6) put_byte(8'h00);
      put_byte(8'hb2);
      put_byte(8'h4d);
      for (int i = 0; i < n; i++) begin
         put_byte(fb[i]);
         c = crc_add(c, fb[i]);
      end
      if (bad_crc) c = ~c;
      put_byte(c[15:8]);
      put_byte(c[7:0]);
      rf_rx <= 1'b0;
   endtask
   initial begin : card
      logic [7:0] len;
      logic [15:0] c;
      logic [15:0] sc;
      logic ok;
      rf_rx = 1'b0;
      got_cnt = 8'h00;
      wait (rstn === 1'b1);
      forever begin
         @(posedge rf_tx);
         v = 1'b0;
         sh = 16'h0000;
         while (sh !== 16'hb24d) get_bit();
         get_byte(len);
         fb[0] = len;
         c = crc_add(16'h0000, len);
         for (int i = 1; i <= len + 1 && i < 32; i++) get_byte(fb[i]);
         for (int i = 1; i < len && i < 32; i++) c = crc_add(c, fb[i]);
         ok = len != 0 && len <= 30 && {fb[len], fb[len + 1]} == c;
         // count before the wait: a short reader timeout must not outrun it
         if (ok) got_cnt <= got_cnt + 8'h01;
         // let the last mid-bit edge pass before hunting again
         repeat (3 * half) @(posedge clk);
         if (ok) begin
            sc = {fb[2], fb[3]};
            if (len == 8'h06 && fb[1] == REQ_CMD && (sc == 16'hffff
                  || (sc == 16'haaff && sys_code[15:8] == 8'haa)
                  || sc == sys_code)) begin
               // slot count in fb[5] is ignored: always the first slot
               repeat (RESP_DLY) @(posedge clk);
               fb[0] = 8'h12;
               fb[1] = REQ_RSP;
               for (int i = 0; i < 8; i++) fb[2 + i] = CARD_ID[63 - 8 * i -: 8];
               {fb[10], fb[11], fb[12], fb[13], fb[14]} = 40'hffff_0000_00;
               {fb[15], fb[16], fb[17]} = {TIME_RD, TIME_WR, 8'hff};
               put_frame(18);
            end
         end
      end
   end
endmodule // cfr_card_model

// ---- tb/test_cfr_reader.sv ----
// test_cfr_reader: request exchanges with the card model through the register bus.
// assumes cfr_reader, cfr_pkg and cfr_card_model are compiled first.
`timescale 1ns/1ps
`include "cfr_defs.svh"
module test_cfr_reader;
   import cfr_pkg::*;
   typedef struct packed {
      logic [15:0] req_sc;
      logic [15:0] stored;
      logic rate;
      logic answer;
      logic bad;
   } cfr_row_t;
   localparam logic [63:0] CARD_ID = 64'h5a5a_1234_0f0f_7788; // arbitrary value
   // E 3, B 1, A 7, n 2: limit 20*12*64 cycles, longer than a reply at 424k
   localparam logic [7:0] TIME_ANS = 8'hcf;
   logic clk = 1'b0, rstn = 1'b0, rf_tx, rf_rx, bad_crc = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] half = 8'd30, got_cnt;
   logic [15:0] sys_code = 16'haaff;
   cfr_status_t status;
   cfr_row_t rows [0:4];
   int cyc = 0, n_errors = 0, n_tests = 0;
   cfr_reader #(.T_CYCLES(20)) u_cfr_reader (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rf_tx, .rf_rx, .status);
   cfr_card_model #(.CARD_ID(CARD_ID)) u_cfr_card_model (.clk, .rstn, .rf_tx, .rf_rx, .half,
      .sys_code, .bad_crc, .got_cnt);
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hs, w_hs;
      aw_hs = 1'b0;
      w_hs = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_hs && w_hs)) begin
         @(posedge clk);
         if (!aw_hs && s_axi_awready === 1'b1) begin
            aw_hs = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_hs && s_axi_wready === 1'b1) begin
            w_hs = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial begin : main
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0] r;
      logic [7:0] cnt;
      logic [39:0] req;
      logic [7:0] exp_b [0:17];
      rows[0] = '{16'hffff, 16'h1234, 1'b1, 1'b1, 1'b0};
      rows[1] = '{16'haaff, 16'haa55, 1'b1, 1'b1, 1'b0};
      rows[2] = '{16'haaff, 16'h1234, 1'b0, 1'b0, 1'b0};
      rows[3] = '{16'h1235, 16'h1234, 1'b1, 1'b0, 1'b0};
      rows[4] = '{16'h1234, 16'h1234, 1'b1, 1'b1, 1'b1};
      {exp_b[0], exp_b[1]} = 16'h1201;
      for (int j = 0; j < 8; j++) exp_b[2 + j] = CARD_ID[63 - 8 * j -: 8];
      for (int j = 0; j < 8; j++) exp_b[10 + j] = 8'(64'hffff_0000_00ff_ffff >> (56 - 8 * j));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         sys_code <= rows[i].stored;
         half <= rows[i].rate ? 8'd30 : 8'd59;
         bad_crc <= rows[i].bad;
         cnt = got_cnt;
         // sixteen slots asked for, the card still answers in the first
         req = {8'h00, rows[i].req_sc, 8'h00, 8'h0f};
         for (int j = 0; j < 5; j++) begin
            axi_wr(`CFR_A_TXBUF + 12'(4 * j), {24'h0, req[39 - 8 * j -: 8]}, r);
         end
         axi_wr(`CFR_A_TXLEN, 32'h0000_0005, r);
         axi_wr(`CFR_A_TIME, {20'h0, 4'h2, rows[i].answer ? TIME_ANS : 8'h00}, r);
         axi_wr(`CFR_A_CTRL, {30'h0, rows[i].rate, 1'b1}, r);
         repeat (3) @(posedge clk);
         while (status.done !== 1'b1) @(posedge clk);
         chk("frames taken", {24'h0, cnt + 8'h01}, {24'h0, got_cnt});
         axi_rd(`CFR_A_STAT, d, r);
         e = rows[i].answer ? {19'h0, 8'h12, 2'b00, ~rows[i].bad, 2'b10} : 32'h0000_000a;
         chk("stat", e, d);
         chk("status port", e >> 1, {20'h0, status});
         for (int j = 0; j < 18 && rows[i].answer; j++) begin
            axi_rd(`CFR_A_RXBUF + 12'(4 * j), d, r);
            chk("rx byte", {24'h0, exp_b[j]}, d);
         end
         $display("row %0d done", i);
      end
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      chk("rf_tx idle", 32'h0, {31'h0, rf_tx});
      axi_rd(`CFR_A_STAT, d, r);
      chk("stat after reset", 32'h0, d);
      chk("status port after reset", 32'h0, {20'h0, status});
      axi_rd(`CFR_A_TIME, d, r);
      chk("time after reset", 32'h0000_01ff, d);
      axi_rd(12'h040, d, r);
      chk("unmapped read", 32'h0000_0002, {d[29:0], r});
      axi_wr(12'h040, 32'h0000_0001, r);
      chk("unmapped write", 32'h0000_0002, {30'h0, r});
      $display("reset test done");
      report_and_stop();
   end
endmodule // test_cfr_reader
